// File: core/cmo_core.sv
module cmo_core #(
  parameter int NUM_OBJ = cmo_pkg::NUM_OBJ
) (
  input  wire logic             mclk_in,
  input  wire logic             srst_in,
  input  wire logic             clk_en_in,
  // ahb-lite slave
  input  wire logic             hsel_in,
  input  wire logic [31:0]      haddr_in,
  input  wire logic [1:0]       htrans_in,
  input  wire logic             hwrite_in,
  input  wire logic [2:0]       hsize_in,
  input  wire logic [31:0]      hwdata_in,
  input  wire logic             hready_in,
  output logic      [31:0]      hrdata_out,
  output logic                  hreadyout_out,
  output logic                  hresp_out,
  // bus line and protocol engine hooks
  input  wire logic             can_rx_in,
  input  wire logic             can_tx_bit_in,
  input  wire logic             can_tx_active_in,
  input  wire logic             arbitration_in,
  input  wire logic             err_frame_in,
  input  wire cmo_pkg::cmo_frame_t frame_in,
  input  wire logic             frame_valid_in,
  input  wire logic [14:0]      rx_match_in,
  output logic                  sample_bit_out,
  output logic                  sample_strobe_out,
  output logic      [14:0]      object_enable_out,
  output logic      [3:0]       tx_object_out,
  output logic                  tx_pending_out,
  output logic                  reply_ok_out,
  output logic                  ext_id_out,
  output logic                  controller_enable_out
);

  // ----------------------------------------------------------------
  // bus slave address phase capture
  // ----------------------------------------------------------------
  logic       wr_pend_reg;
  logic       rd_pend_reg;
  logic [7:0] idx_reg;
  logic       wr_go;
  logic [7:0] wdat;
  logic       data_acc;

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign wr_go         = wr_pend_reg & clk_en_in;
  assign wdat          = hwdata_in[7:0];

  // single-cycle answer; only word transfers are expected
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg     <= 8'h00;
    end else if (clk_en_in) begin
      wr_pend_reg <= hsel_in & hready_in & htrans_in[1] & hwrite_in;
      rd_pend_reg <= hsel_in & hready_in & htrans_in[1] & ~hwrite_in;
      // select held across the data phase so the read mux keeps its address
      if (hsel_in & hready_in & htrans_in[1]) idx_reg <= haddr_in[9:2];
    end
  end

  // ----------------------------------------------------------------
  // page, timing and global registers
  // ----------------------------------------------------------------
  logic [7:0] page_reg;
  logic [6:0] timing3_reg;
  logic [5:0] prescaler_reg;
  logic [1:0] jump_reg;
  logic [2:0] prop_reg;
  logic       enable_reg;
  logic [3:0] obj;
  logic [2:0] data_byte_index;

  assign obj             = page_reg[7:cmo_pkg::PAGE_OBJ_LSB];
  assign data_byte_index = page_reg[2:0];
  assign data_acc        = (wr_go | (rd_pend_reg & clk_en_in)) && idx_reg == cmo_pkg::IDX_DATA;
  assign controller_enable_out = enable_reg;

  // page register with index auto-increment after data accesses
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      page_reg <= cmo_pkg::PAGE_RESET;
    end else if (wr_go && idx_reg == cmo_pkg::IDX_PAGE) begin
      page_reg <= wdat;
    end else if (data_acc && !page_reg[cmo_pkg::PAGE_INDEX_AUTOINC_N_BIT]) begin
      page_reg[2:0] <= data_byte_index + 3'd1;
    end
  end

  // timing fields: software only changes these while disabled
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      timing3_reg   <= 7'h00;
      prescaler_reg <= 6'h00;
      jump_reg      <= 2'h0;
      prop_reg      <= 3'h0;
      enable_reg    <= 1'b0;
    end else if (wr_go) begin
      if (idx_reg == cmo_pkg::IDX_TIMING3) timing3_reg <= wdat[6:0];
      if (idx_reg == cmo_pkg::IDX_TIMING1) prescaler_reg <= wdat[6:1];
      if (idx_reg == cmo_pkg::IDX_TIMING2) begin
        jump_reg <= wdat[6:5];
        prop_reg <= wdat[3:1];
      end
      if (idx_reg == cmo_pkg::IDX_GLOBAL) enable_reg <= wdat[1];
    end
  end

  // ----------------------------------------------------------------
  // per-object storage
  // ----------------------------------------------------------------
  cmo_pkg::cmo_ctl_t ctl_reg [NUM_OBJ];
  logic [7:0]        stat_reg [NUM_OBJ];
  logic [7:0]        idt_reg [NUM_OBJ];
  logic [7:0]        data_reg [NUM_OBJ][8];
  logic [NUM_OBJ-1:0] en_reg;
  logic [3:0]        served_reg;
  logic              bit_err_reg;

  // lowest set bit of a vector picks the served object
  function automatic logic [3:0] lowest(input logic [14:0] v);
    lowest = 4'hF;
    for (int k = 14; k >= 0; k--) begin
      if (v[k]) lowest = 4'(k);
    end
  endfunction

  logic [3:0]  rx_obj;
  logic [14:0] tx_req;

  // producers; a process so it follows every config write
  always_comb begin
    tx_req = '0;
    for (int k = 0; k < NUM_OBJ; k++) begin
      tx_req[k] = ctl_reg[k].cfg == cmo_pkg::CMO_CFG_TX;
    end
  end

  assign rx_obj         = lowest(rx_match_in & en_reg);
  assign tx_object_out  = lowest(en_reg & tx_req);
  assign tx_pending_out = tx_object_out != 4'hF;
  assign object_enable_out = en_reg;

  // served object latched for the frame report
  always_ff @(posedge mclk_in) begin
    if (srst_in) served_reg <= 4'hF;
    else if (clk_en_in && frame_valid_in) served_reg <= frame_in.tx_done ? tx_object_out : rx_obj;
  end

  logic rep_valid;
  assign rep_valid    = frame_valid_in && clk_en_in;
  assign ext_id_out   = (obj <= cmo_pkg::OBJ_LAST) ? ctl_reg[obj].ide : 1'b0;
  assign reply_ok_out = (rx_obj != 4'hF) && ctl_reg[rx_obj].reply_valid;

  genvar g;
  generate
    for (g = 0; g < NUM_OBJ; g++) begin : g_obj
      logic sel, hit, sw_clr;
      logic [7:0] set_v;
      assign sel    = obj == 4'(g);
      assign hit    = rep_valid && (frame_in.tx_done ? tx_object_out == 4'(g) : rx_obj == 4'(g));
      assign sw_clr = wr_go && sel && idx_reg == cmo_pkg::IDX_STATUS;

      // config, length and enable; received length stored unless a control write to the object lands in the same cycle
      always_ff @(posedge mclk_in) begin
        if (srst_in) begin
          ctl_reg[g] <= '0;
          en_reg[g]  <= 1'b0;
          idt_reg[g] <= 8'h00;
        end else begin
          if (wr_go && sel && idx_reg == cmo_pkg::IDX_CONTROL) begin
            ctl_reg[g] <= cmo_pkg::cmo_ctl_t'(wdat);
            en_reg[g]  <= wdat[7:6] != 2'b00;
          end else if (hit && frame_in.rx_done) begin
            ctl_reg[g].dlc <= frame_in.dlc;
            if (ctl_reg[g].cfg != cmo_pkg::CMO_CFG_RXBUF) en_reg[g] <= 1'b0;
          end else if (hit && frame_in.tx_done) begin
            en_reg[g] <= 1'b0;
          end
          if (wr_go && sel && idx_reg == cmo_pkg::IDX_IDTAG1) idt_reg[g] <= wdat;
        end
      end

      // flags raised by this object's report; errors come as bit,stuff,crc,form,ack
      always_comb begin
        set_v = '0;
        if (hit) begin
          set_v[cmo_pkg::ST_TRANSMIT_DONE] = frame_in.tx_done;
          set_v[cmo_pkg::ST_RECEIVE_DONE] = frame_in.rx_done;
          set_v[cmo_pkg::ST_LENW] = frame_in.rx_done && frame_in.dlc != ctl_reg[g].dlc;
          set_v[cmo_pkg::ST_BIT_ERROR_FLAG] = frame_in.errors[4] | bit_err_reg;
          set_v[cmo_pkg::ST_STUFF_ERROR_FLAG] = frame_in.errors[3];
          set_v[cmo_pkg::ST_CRC_ERROR_FLAG] = frame_in.errors[2];
          set_v[cmo_pkg::ST_FORM_ERROR_FLAG] = frame_in.errors[1];
          set_v[cmo_pkg::ST_ACK_ERROR_FLAG] = frame_in.errors[0];
        end
      end

      // sticky status: hardware set wins over software clear
      always_ff @(posedge mclk_in) begin
        if (srst_in) begin
          stat_reg[g] <= 8'h00;
        end else begin
          stat_reg[g] <= ((sw_clr ? (stat_reg[g] & wdat) : stat_reg[g])) | set_v;
        end
      end

      // data bytes, written at the current index
      always_ff @(posedge mclk_in) begin
        if (wr_go && sel && idx_reg == cmo_pkg::IDX_DATA) begin
          data_reg[g][data_byte_index] <= wdat;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // bit timing: quantum, segments, resync, sampling
  // ----------------------------------------------------------------
  logic [2:0] rx_sync_reg;
  logic [6:0] pre_cnt_reg;
  logic       tq_tick;
  logic       half_tick;
  cmo_pkg::cmo_seg_t seg_reg;
  logic [3:0] seg_cnt_reg;
  logic [3:0] seg_len_reg;
  logic       rx_prev_reg;
  logic [2:0] smp_reg;
  logic       edge_seen;
  logic [3:0] jump_width;
  logic [3:0] ph1_len;
  logic [3:0] ph2_len;

  assign jump_width     = {2'b00, jump_reg} + 4'd1;
  assign ph1_len = {1'b0, timing3_reg[3:1]} + 4'd1;
  assign ph2_len = {1'b0, timing3_reg[6:4]} + 4'd1;
  // quantum of prescaler plus one clocks, half marked mid-way
  assign tq_tick   = clk_en_in && pre_cnt_reg == {1'b0, prescaler_reg};
  assign half_tick = clk_en_in && pre_cnt_reg == {2'b00, prescaler_reg[5:1]};
  assign edge_seen = rx_sync_reg[2] != rx_prev_reg && !rx_sync_reg[2];

  // bus line synchroniser; stage 0 feeds stage 1 only
  always_ff @(posedge mclk_in) begin
    if (srst_in) rx_sync_reg <= 3'b111;
    else if (clk_en_in) rx_sync_reg <= {rx_sync_reg[1:0], can_rx_in};
  end

  // prescaler counter
  always_ff @(posedge mclk_in) begin
    if (srst_in || !enable_reg) pre_cnt_reg <= 7'h00;
    else if (tq_tick) pre_cnt_reg <= 7'h00;
    else if (clk_en_in) pre_cnt_reg <= pre_cnt_reg + 7'd1;
  end

  // segment sequencer with bounded resync on early and late edges
  always_ff @(posedge mclk_in) begin
    if (srst_in || !enable_reg) begin
      seg_reg     <= cmo_pkg::CMO_SEG_SYNC;
      seg_cnt_reg <= 4'h0;
      seg_len_reg <= 4'h1;
      rx_prev_reg <= 1'b1;
    end else if (tq_tick) begin
      rx_prev_reg <= rx_sync_reg[2];
      if (edge_seen && seg_reg == cmo_pkg::CMO_SEG_PH2) begin
        // early edge: shorten phase two by at most the jump width
        if (ph2_len - seg_cnt_reg <= jump_width) begin
          seg_reg <= cmo_pkg::CMO_SEG_SYNC;
          seg_cnt_reg <= 4'h0;
        end else begin
          seg_len_reg <= seg_len_reg - jump_width;
          seg_cnt_reg <= seg_cnt_reg + 4'd1;
        end
      end else if (seg_cnt_reg + 4'd1 >= seg_len_reg) begin
        seg_cnt_reg <= 4'h0;
        unique case (seg_reg)
          cmo_pkg::CMO_SEG_SYNC: begin
            seg_reg <= cmo_pkg::CMO_SEG_PROP;
            seg_len_reg <= {1'b0, prop_reg} + 4'd1;
          end
          cmo_pkg::CMO_SEG_PROP: begin
            seg_reg <= cmo_pkg::CMO_SEG_PH1;
            seg_len_reg <= ph1_len;
          end
          cmo_pkg::CMO_SEG_PH1: begin
            seg_reg <= cmo_pkg::CMO_SEG_PH2;
            seg_len_reg <= ph2_len;
          end
          cmo_pkg::CMO_SEG_PH2: begin
            seg_reg <= cmo_pkg::CMO_SEG_SYNC;
            seg_len_reg <= 4'h1;
          end
        endcase
      end else begin
        seg_cnt_reg <= seg_cnt_reg + 4'd1;
        // late edge in phase one: lengthen by at most the jump width
        if (edge_seen && seg_reg == cmo_pkg::CMO_SEG_PH1 && seg_len_reg == ph1_len)
          seg_len_reg <= ph1_len + jump_width;
      end
    end
  end

  // three samples half a quantum apart ending at the sample point
  logic smp_point;
  assign smp_point = tq_tick && seg_reg == cmo_pkg::CMO_SEG_PH1 && seg_cnt_reg + 4'd1 >= seg_len_reg;
  always_ff @(posedge mclk_in) begin
    if (srst_in) smp_reg <= 3'b111;
    else if (half_tick || tq_tick) smp_reg <= {smp_reg[1:0], rx_sync_reg[2]};
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sample_bit_out    <= 1'b1;
      sample_strobe_out <= 1'b0;
    end else if (clk_en_in) begin
      sample_strobe_out <= smp_point;
      if (smp_point) begin
        sample_bit_out <= timing3_reg[0] ?
          ((smp_reg[0] & smp_reg[1]) | (smp_reg[1] & rx_sync_reg[2]) |
           (smp_reg[0] & rx_sync_reg[2])) : rx_sync_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx_reg)
      cmo_pkg::IDX_PAGE:    rd_byte = page_reg;
      cmo_pkg::IDX_STATUS:  rd_byte = (obj <= cmo_pkg::OBJ_LAST) ? stat_reg[obj] : 8'h00;
      cmo_pkg::IDX_CONTROL: rd_byte = (obj <= cmo_pkg::OBJ_LAST) ? 8'(ctl_reg[obj]) : 8'h00;
      cmo_pkg::IDX_IDTAG1:  rd_byte = (obj <= cmo_pkg::OBJ_LAST) ? idt_reg[obj] : 8'h00;
      cmo_pkg::IDX_DATA:    rd_byte = (obj <= cmo_pkg::OBJ_LAST) ? data_reg[obj][data_byte_index] : 8'h00;
      cmo_pkg::IDX_TIMING3: rd_byte = {1'b0, timing3_reg};
      cmo_pkg::IDX_TIMING1: rd_byte = {1'b0, prescaler_reg, 1'b0};
      cmo_pkg::IDX_TIMING2: rd_byte = {1'b0, jump_reg, 1'b0, prop_reg, 1'b0};
      cmo_pkg::IDX_GLOBAL:  rd_byte = {6'h00, enable_reg, 1'b0};
      cmo_pkg::IDX_EVENT:   rd_byte = {tx_pending_out, 3'h0, tx_object_out};
      default:              rd_byte = 8'h00;
    endcase
  end
  assign hrdata_out = {24'h00_0000, rd_byte};

  // bit error while sending latched per sample, folded into the report
  always_ff @(posedge mclk_in) begin
    if (srst_in) bit_err_reg <= 1'b0;
    else if (clk_en_in && sample_strobe_out && can_tx_active_in)
      bit_err_reg <= (sample_bit_out != can_tx_bit_in) &&
                     !(arbitration_in && can_tx_bit_in) && !err_frame_in;
  end

endmodule

// File: core/cmo_pkg.sv
package cmo_pkg;

  // ----------------------------------------------------------------
  // register map (word indices, haddr[9:2], on the word bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PAGE    = 8'hB1;
  localparam logic [7:0] OFS_STATUS  = 8'hB2;
  localparam logic [7:0] OFS_CONTROL = 8'hB3;
  localparam logic [7:0] OFS_IDTAG1  = 8'hBC;
  localparam logic [7:0] IDX_PAGE    = 8'hB1;
  localparam logic [7:0] IDX_STATUS  = 8'hB2;
  localparam logic [7:0] IDX_CONTROL = 8'hB3;
  localparam logic [7:0] IDX_IDTAG1  = 8'hBC;
  localparam logic [7:0] IDX_TIMING3 = 8'hB6;
  localparam logic [7:0] IDX_TIMING1 = 8'hB4;
  localparam logic [7:0] IDX_TIMING2 = 8'hB5;
  localparam logic [7:0] IDX_GLOBAL  = 8'hC0;
  localparam logic [7:0] IDX_DATA    = 8'hC1;
  localparam logic [7:0] IDX_EVENT   = 8'hC2;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          PAGE_OBJ_LSB   = 4;
  localparam int          PAGE_INDEX_AUTOINC_N_BIT  = 3;
  localparam logic [7:0]  PAGE_RESET     = 8'h00;
  localparam int          CTL_CFG_LSB    = 6;
  localparam int          CTL_REPLY_VALID_BIT   = 5;
  localparam int          CTL_IDE_BIT    = 4;
  localparam logic [3:0]  DLC_MAX        = 4'h8;
  localparam logic [3:0]  OBJ_LAST       = 4'hE;
  localparam int          NUM_OBJ        = 15;
  localparam logic [1:0]  INFO_PROC_TQ   = 2'h2;

  // status bit positions
  localparam int ST_LENW = 7;
  localparam int ST_TRANSMIT_DONE = 6;
  localparam int ST_RECEIVE_DONE = 5;
  localparam int ST_BIT_ERROR_FLAG = 4;
  localparam int ST_STUFF_ERROR_FLAG = 3;
  localparam int ST_CRC_ERROR_FLAG = 2;
  localparam int ST_FORM_ERROR_FLAG = 1;
  localparam int ST_ACK_ERROR_FLAG = 0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMO_CFG_DISABLE = 2'b00,
    CMO_CFG_TX      = 2'b01,
    CMO_CFG_RX      = 2'b10,
    CMO_CFG_RXBUF   = 2'b11
  } cmo_cfg_t;

  typedef enum logic [3:0] {
    CMO_SEG_SYNC  = 4'b0001,
    CMO_SEG_PROP  = 4'b0010,
    CMO_SEG_PH1   = 4'b0100,
    CMO_SEG_PH2   = 4'b1000
  } cmo_seg_t;

  typedef struct packed {
    cmo_cfg_t   cfg;
    logic       reply_valid;
    logic       ide;
    logic [3:0] dlc;
  } cmo_ctl_t;

  // one finished-frame report from the protocol engine
  typedef struct packed {
    logic       tx_done;
    logic       rx_done;
    logic       remote;
    logic [3:0] dlc;
    logic [4:0] errors;
  } cmo_frame_t;

endpackage

// File: dv/cmo_core_props.sv
// ----------------------------------------------------------------
// port checker for the message object block
// ----------------------------------------------------------------
module cmo_core_props #(
  parameter int NUM_OBJ = 15
) (
  input wire logic        mclk_in,
  input wire logic        srst_in,
  input wire logic        clk_en_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        sample_bit_out,
  input wire logic        sample_strobe_out,
  input wire logic [14:0] object_enable_out,
  input wire logic [3:0]  tx_object_out,
  input wire logic        tx_pending_out,
  input wire logic        controller_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  logic take_wr;
  logic ctl_wr_reg;

  // accepted write address phase
  assign take_wr = hsel_in && hready_in && htrans_in[1] && hwrite_in && clk_en_in;

  // remembers a control write so an enable bit rising can be traced to it
  always_ff @(posedge mclk_in) begin
    ctl_wr_reg <= !srst_in && take_wr && (haddr_in[11:0] == 12'h2cc);
  end

  ready_always_a: assert property (hreadyout_out == 1'b1)
    else $error("slave inserted a wait state");
  okay_resp_a: assert property (hresp_out == 1'b0)
    else $error("slave answered with error");
  byte_lane_a: assert property (hrdata_out[31:8] == 24'h00_0000)
    else $error("read data outside low byte");
  strobe_single_a: assert property (sample_strobe_out |=> !sample_strobe_out)
    else $error("sample strobe longer than one cycle");
  pend_code_a: assert property (tx_pending_out == (tx_object_out != 4'hf))
    else $error("pending flag and object code disagree");
  pend_enabled_a: assert property (tx_pending_out |->
    object_enable_out[tx_object_out] && (tx_object_out < NUM_OBJ))
    else $error("pending object not enabled");
  reset_clear_a: assert property ($fell(srst_in) |->
    object_enable_out == 15'h0000 && !controller_enable_out && sample_bit_out)
    else $error("state not cleared by reset");
  enable_write_a: assert property (take_wr && haddr_in[11:0] == 12'h300 |=>
    ##1 controller_enable_out == $past(hwdata_in[1]))
    else $error("controller enable did not follow write");
  arm_by_write_a: assert property ((|(object_enable_out & ~$past(object_enable_out))) |->
    $past(ctl_wr_reg))
    else $error("object enabled without a control write");
endmodule

bind cmo_core cmo_core_props #(.NUM_OBJ(NUM_OBJ)) u_cmo_core_props (
  .mclk_in(mclk_in), .srst_in(srst_in), .clk_en_in(clk_en_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .sample_bit_out(sample_bit_out),
  .sample_strobe_out(sample_strobe_out), .object_enable_out(object_enable_out),
  .tx_object_out(tx_object_out), .tx_pending_out(tx_pending_out),
  .controller_enable_out(controller_enable_out)
);

// File: dv/cmo_core_tb_top.sv
module cmo_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                mclk_in, srst_in, hsel, hwrite, clk_en;
  logic [1:0]          htrans;
  logic [31:0]         haddr, hwdata, rd;
  wire logic [31:0]    hrdata;
  wire logic           hready, can_rx, fval, sbit, sstb, txp, rok, ext, cen;
  wire logic [3:0]     eng, txo;
  wire logic [14:0]    hits, oen;
  wire cmo_pkg::cmo_frame_t frame;
  int                  bad_count = 0;
  int                  n_checks = 0;
  int                  k;
  // address, write data, expected read back
  localparam logic [27:0] ROWS [7] = '{
    {12'h2c4, 8'he8, 8'he8}, {12'h2f0, 8'ha5, 8'ha5}, {12'h2cc, 8'h98, 8'h98},
    {12'h2d8, 8'h52, 8'h52}, {12'h3fc, 8'hff, 8'h00}, {12'h2c8, 8'hff, 8'h00},
    {12'h2c4, 8'h20, 8'h20}};

  cmo_core u_cmo_core (
    .mclk_in(mclk_in), .srst_in(srst_in), .clk_en_in(clk_en), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(), .can_rx_in(can_rx), .can_tx_bit_in(eng[3]), .can_tx_active_in(eng[2]),
    .arbitration_in(eng[1]), .err_frame_in(eng[0]), .frame_in(frame),
    .frame_valid_in(fval), .rx_match_in(hits), .sample_bit_out(sbit),
    .sample_strobe_out(sstb), .object_enable_out(oen), .tx_object_out(txo),
    .tx_pending_out(txp), .reply_ok_out(rok), .ext_id_out(ext),
    .controller_enable_out(cen));

  cmo_node_model u_cmo_node_model (
    .mclk_in(mclk_in), .can_rx_out(can_rx), .engine_out(eng), .frame_out(frame),
    .frame_valid_out(fval), .rx_match_out(hits));

  // ----------------------------------------------------------------
  // clock, verdict, watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // bus master and compares
  // ----------------------------------------------------------------
  // single word transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h0_0000, a};
    do @(posedge mclk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    do @(posedge mclk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // callers sample pins at the falling edge, once the rising edge has landed
  task automatic chk_pin(input logic [14:0] got, input logic [14:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
    @(posedge mclk_in);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst_in = 1'b1;
    clk_en = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    repeat (20) @(posedge mclk_in);
    srst_in <= 1'b0;
    @(posedge mclk_in);
    xfer(1'b0, 12'h2c4, 8'h00);
    chk_reg(rd[7:0], 8'h00);
    $display("reset values done");
    // plain register cases; timing written while the controller is off
    foreach (ROWS[i]) begin
      xfer(1'b1, ROWS[i][27:16], ROWS[i][15:8]);
      xfer(1'b0, ROWS[i][27:16], 8'h00);
      chk_reg(rd[7:0], ROWS[i][7:0]);
    end
    $display("register table done");
    // index steps per data access and wraps; held when the bit is set
    xfer(1'b1, 12'h2c4, 8'h16);
    xfer(1'b1, 12'h304, 8'h11);
    xfer(1'b1, 12'h304, 8'h22);
    xfer(1'b0, 12'h2c4, 8'h00);
    chk_reg(rd[7:0], 8'h10);
    xfer(1'b1, 12'h2c4, 8'h1e);
    xfer(1'b1, 12'h304, 8'h33);
    xfer(1'b0, 12'h2c4, 8'h00);
    chk_reg(rd[7:0], 8'h1e);
    xfer(1'b0, 12'h304, 8'h00);
    chk_reg(rd[7:0], 8'h33);
    xfer(1'b1, 12'h2c4, 8'h17);
    xfer(1'b0, 12'h304, 8'h00);
    chk_reg(rd[7:0], 8'h22);
    xfer(1'b0, 12'h2c4, 8'h00);
    chk_reg(rd[7:0], 8'h10);
    $display("auto increment done");
    // every configuration code on object 5
    xfer(1'b1, 12'h2c4, 8'h50);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 12'h2cc, {c[1:0], 6'h03});
      @(negedge mclk_in) chk_pin({14'h0000, oen[5]}, {14'h0000, c != 0});
      @(negedge mclk_in) chk_pin({11'h000, txo}, (c == 1) ? 15'h0005 : 15'h000f);
    end
    // two producers: the lower one goes first, then the other
    xfer(1'b1, 12'h2cc, 8'h43);
    xfer(1'b1, 12'h2c4, 8'h20);
    xfer(1'b1, 12'h2cc, 8'h43);
    @(negedge mclk_in) chk_pin({11'h000, txo}, 15'h0002);
    xfer(1'b1, 12'h2cc, 8'h03);
    @(negedge mclk_in) chk_pin({11'h000, txo}, 15'h0005);
    $display("configuration done");
    // reply only with reply valid set, then a frame with a new length
    xfer(1'b1, 12'h2cc, 8'h93);
    u_cmo_node_model.set_hits(15'h0004);
    @(negedge mclk_in) chk_pin({14'h0000, ext}, 15'h0001);
    @(negedge mclk_in) chk_pin({14'h0000, rok}, 15'h0000);
    xfer(1'b1, 12'h2cc, 8'ha3);
    @(negedge mclk_in) chk_pin({14'h0000, rok}, 15'h0001);
    u_cmo_node_model.report({1'b0, 1'b1, 1'b0, 4'h5, 5'h00});
    repeat (2) @(posedge mclk_in);
    xfer(1'b0, 12'h2cc, 8'h00);
    chk_reg({4'h0, rd[3:0]}, 8'h05);
    xfer(1'b0, 12'h2c8, 8'h00);
    chk_reg(rd[7:0], 8'ha0);
    xfer(1'b0, 12'h2c8, 8'h00);
    chk_reg(rd[7:0], 8'ha0);
    xfer(1'b1, 12'h2c8, 8'h00);
    xfer(1'b0, 12'h2c8, 8'h00);
    chk_reg(rd[7:0], 8'h00);
    $display("reception done");
    // single then triple sampling; timing rewritten only while disabled
    xfer(1'b1, 12'h300, 8'h02);
    @(negedge mclk_in) chk_pin({14'h0000, cen}, 15'h0001);
    for (int lv = 0; lv < 4; lv++) begin
      xfer(1'b1, 12'h300, 8'h00);
      xfer(1'b1, 12'h2d8, {7'h29, lv[1]});
      xfer(1'b1, 12'h300, 8'h02);
      u_cmo_node_model.drive_rx(lv[0]);
      repeat (12) @(posedge mclk_in);
      k = 0;
      while (sstb !== 1'b1 && k < 300) begin
        @(posedge mclk_in);
        k++;
      end
      @(negedge mclk_in) chk_pin({14'h0000, sbit}, {14'h0000, lv[0]});
    end
    xfer(1'b1, 12'h300, 8'h00);
    $display("sampling done");
    // reset in mid-run clears page and enables
    srst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    srst_in <= 1'b0;
    @(posedge mclk_in);
    xfer(1'b0, 12'h2c4, 8'h00);
    chk_reg(rd[7:0], 8'h00);
    @(negedge mclk_in) chk_pin(oen, 15'h0000);
    // a write while the clock enable is low must leave no trace
    clk_en <= 1'b0;
    xfer(1'b1, 12'h2c4, 8'h70);
    clk_en <= 1'b1;
    xfer(1'b0, 12'h2c4, 8'h00);
    chk_reg(rd[7:0], 8'h00);
    $display("second reset done");
    test_done();
  end
endmodule

// File: dv/cmo_node_model.sv
// ----------------------------------------------------------------
// other nodes on the bus, seen through the engine hooks
// ----------------------------------------------------------------
module cmo_node_model (
  input  wire logic          mclk_in,
  output logic               can_rx_out,
  output logic [3:0]         engine_out,
  output cmo_pkg::cmo_frame_t frame_out,
  output logic               frame_valid_out,
  output logic [14:0]        rx_match_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idles recessive through its pull-up, engine idle
  initial begin
    can_rx_out = 1'b1;
    engine_out = 4'b1000;
    frame_out = '0;
    frame_valid_out = 1'b0;
    rx_match_out = 15'h0000;
  end

  // acceptance hits stand as a level until the next filter result
  task automatic set_hits(input logic [14:0] h);
    rx_match_out <= h;
  endtask

  // one-cycle report; fields scrambled after so a stale copy never looks valid
  task automatic report(input cmo_pkg::cmo_frame_t f);
    frame_out <= f;
    frame_valid_out <= 1'b1;
    @(posedge mclk_in);
    frame_valid_out <= 1'b0;
    frame_out <= ~f;
  endtask

  // level another node forces onto the wire
  task automatic drive_rx(input logic lvl);
    can_rx_out <= lvl;
  endtask
endmodule
